/* File: core/apb_regs_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface apb_regs_if;
    logic [7:0] busControl;
    logic [1:0] speedControl;
    logic [7:0] statusWord;
    logic cmdWait;
    logic cmdHalt;
    logic cmdWatchdog;
    modport regs (output busControl, output speedControl, input statusWord,
                  output cmdWait, output cmdHalt, output cmdWatchdog);
    modport core (input busControl, input speedControl, output statusWord,
                  input cmdWait, input cmdHalt, input cmdWatchdog);
endinterface
`default_nettype wire

/* File: core/apb_sysctl_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module apb_sysctl_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic resetRise,
    input wire logic busSurrenderAtReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    apb_regs_if.regs regs
);

    logic access;
    logic [7:0] busControl;
    logic [1:0] speedControl;
    logic [2:0] cmd;

    assign access = psel && penable && pready;
    assign regs.busControl = busControl;
    assign regs.speedControl = speedControl;
    assign regs.cmdWait = cmd[sysctl_pkg::CMD_WAIT_BIT];
    assign regs.cmdHalt = cmd[sysctl_pkg::CMD_HALT_BIT];
    assign regs.cmdWatchdog = cmd[sysctl_pkg::CMD_WATCHDOG_BIT];

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge core_clk) begin
        if (rst || access) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable;
        end
    end

    // Speed control, oscillator off after reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            speedControl <= sysctl_pkg::SPEED_CTRL_RESET;
        end else if (access && pwrite && paddr == sysctl_pkg::SPEED_CTRL_OFFSET) begin
            speedControl <= pwdata[1:0];
        end
    end

    // Bus control loaded on reset release from the surrender pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busControl <= sysctl_pkg::BUS_CTRL_NORMAL;
        end else if (resetRise) begin
            busControl <= busSurrenderAtReset ? sysctl_pkg::BUS_CTRL_NORMAL
                                              : sysctl_pkg::BUS_CTRL_EMULATION;
        end else if (access && pwrite && paddr == sysctl_pkg::BUS_CTRL_OFFSET) begin
            busControl <= pwdata[7:0];
        end
    end

    // Command pulses, one cycle each
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd <= 3'h0;
        end else if (access && pwrite && paddr == sysctl_pkg::CORE_CMD_OFFSET) begin
            cmd <= pwdata[2:0];
        end else begin
            cmd <= 3'h0;
        end
    end

    // Read data and error answer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= 1'b0;
            case (paddr)
                sysctl_pkg::SPEED_CTRL_OFFSET: prdata <= {30'h0, speedControl};
                sysctl_pkg::BUS_CTRL_OFFSET: prdata <= {24'h0, busControl};
                sysctl_pkg::STATUS_OFFSET: prdata <= {24'h0, regs.statusWord};
                sysctl_pkg::CORE_CMD_OFFSET: prdata <= 32'h0;
                default: begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: core/sysctl_pkg.sv */
package sysctl_pkg;

    // ***********************************************************
    // Register map
    // ***********************************************************
    localparam logic [11:0] SPEED_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] BUS_CTRL_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] CORE_CMD_OFFSET = 12'h00c;

    // Speed control fields
    localparam int FAST_OSC_ENABLE_BIT = 0;
    localparam int PHASE_CLOCK_SOURCE_BIT = 1;
    localparam logic [1:0] SPEED_CTRL_RESET = 2'h0;

    // Bus control fields and reset loads
    localparam int EXTERNAL_BUS_ENABLE_BIT = 0;
    localparam int EMULATION_MODE_BIT = 3;
    localparam int EXTERNAL_MEMORY_BIT = 7;
    localparam logic [7:0] BUS_CTRL_EMULATION = 8'h89;
    localparam logic [7:0] BUS_CTRL_NORMAL = 8'h00;

    // Core command bits (written, self clearing)
    localparam int CMD_WAIT_BIT = 0;
    localparam int CMD_HALT_BIT = 1;
    localparam int CMD_WATCHDOG_BIT = 2;

    // ***********************************************************
    // Timing counts
    // ***********************************************************
    localparam logic [3:0] RESET_SEQUENCE_CYCLES = 4'h9;
    localparam logic [1:0] LOW_POWER_PHASE_CYCLES = 2'h2;
    localparam logic [3:0] WATCHDOG_PULSE_CYCLES = 4'h4;

    // Run state of the processor core
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_BOOT = 2'b01,
        ST_RUN = 2'b11,
        ST_STOPPED = 2'b10
    } run_state_type;

endpackage

/* File: core/system_clock_run_bus_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_run_bus_reset_control (
    input wire logic core_clk,
    input wire logic rst,
    // APB register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock pins, sampled as levels
    input wire logic slowClockIn,
    input wire logic fast_clock_in,
    output logic slow_osc_drive_out,
    output logic fast_osc_drive_out,
    output logic fastOscEnable,
    output logic system_phase_clock,
    output logic phase_clock_inverted,
    // Core side
    input wire logic opcodeFetch,
    input wire logic coreWrite,
    input wire logic coreExternal,
    input wire logic coreAccess,
    input wire logic coreReady,
    input wire logic [15:0] coreAddr,
    input wire logic [7:0] coreWriteData,
    input wire logic irqPending,
    output logic coreHalt,
    output logic coreReset,
    output logic bootActive,
    output logic lowPower,
    // Pins
    input wire logic bus_surrender_in,
    input wire logic system_reset_n_in,
    output logic system_reset_n_out,
    output logic system_reset_n_oe,
    input wire logic write_strobe_n_in,
    output logic write_strobe_n_out,
    output logic write_strobe_n_oe,
    output logic [15:0] addrOut,
    output logic addrOe,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic runPin,
    output logic [15:0] dmaAddr,
    output logic dmaWrite,
    output logic dmaValid
);

    // ***********************************************************
    // Register file
    // ***********************************************************
    apb_regs_if regBus ();
    logic resetPinLevel;
    logic resetRise;
    logic phase;
    logic runLevel;
    logic emulation;
    sysctl_pkg::run_state_type runState;
    sysctl_pkg::run_state_type next_runState;
    logic [3:0] bootCount;
    logic [1:0] lowCount;
    logic [3:0] watchdogCount;
    logic haltedClock;
    logic surrenderLowPhase;

    apb_sysctl_regs regsInst (
        .core_clk(core_clk),
        .rst(rst),
        .resetRise(resetRise),
        .busSurrenderAtReset(bus_surrender_in),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regs(regBus.regs)
    );

    assign emulation = regBus.busControl[sysctl_pkg::EMULATION_MODE_BIT];
    assign regBus.statusWord = {lowPower, bootActive, coreHalt, runLevel,
                                haltedClock, surrenderLowPhase, runState};

    // ***********************************************************
    // Reset pin edge and low-power entry
    // ***********************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resetPinLevel <= 1'b1; // Idle level of the pin, so no false rise after reset
        end else begin
            resetPinLevel <= system_reset_n_in;
        end
    end
    assign resetRise = system_reset_n_in && !resetPinLevel;

    // Count phase cycles with reset low
    always_ff @(posedge core_clk) begin
        if (rst || system_reset_n_in) begin
            lowCount <= 2'h0;
            lowPower <= 1'b0;
        end else if (phase && !system_phase_clock) begin
            if (lowCount != sysctl_pkg::LOW_POWER_PHASE_CYCLES) begin
                lowCount <= lowCount + 2'h1;
            end
            lowPower <= lowCount + 2'h1 >= sysctl_pkg::LOW_POWER_PHASE_CYCLES;
        end
    end

    // Monitor timeout pulls reset pin low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdogCount <= 4'h0;
        end else if (regBus.cmdWatchdog) begin
            watchdogCount <= sysctl_pkg::WATCHDOG_PULSE_CYCLES;
        end else if (watchdogCount != 4'h0) begin
            watchdogCount <= watchdogCount - 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            system_reset_n_oe <= 1'b0;
            system_reset_n_out <= 1'b0;
        end else begin
            system_reset_n_oe <= regBus.cmdWatchdog || watchdogCount > 4'h1;
            system_reset_n_out <= 1'b0;
        end
    end

    // ***********************************************************
    // Clocks
    // ***********************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            slow_osc_drive_out <= 1'b1;
            fast_osc_drive_out <= 1'b1;
            fastOscEnable <= 1'b0;
        end else begin
            slow_osc_drive_out <= !slowClockIn;
            fast_osc_drive_out <= !(fast_clock_in && regBus.speedControl[sysctl_pkg::FAST_OSC_ENABLE_BIT]);
            fastOscEnable <= regBus.speedControl[sysctl_pkg::FAST_OSC_ENABLE_BIT];
        end
    end

    // Phase clock source select, frozen at its current level while halted
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase <= 1'b0;
        end else if (!haltedClock) begin
            phase <= regBus.speedControl[sysctl_pkg::PHASE_CLOCK_SOURCE_BIT]
                     ? fast_clock_in : slowClockIn;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            system_phase_clock <= 1'b0;
            phase_clock_inverted <= 1'b1;
        end else begin
            system_phase_clock <= phase;
            phase_clock_inverted <= !phase;
        end
    end

    // ***********************************************************
    // Run state machine
    // ***********************************************************
    always_comb begin
        next_runState = runState;
        case (runState)
            sysctl_pkg::ST_RESET: begin
                if (resetRise) begin
                    next_runState = sysctl_pkg::ST_BOOT;
                end
            end
            sysctl_pkg::ST_BOOT: begin
                if (bootCount == 4'h1) begin
                    next_runState = sysctl_pkg::ST_RUN;
                end
            end
            sysctl_pkg::ST_RUN: begin
                if ((regBus.cmdWait || regBus.cmdHalt) && phase) begin
                    next_runState = sysctl_pkg::ST_STOPPED;
                end
            end
            sysctl_pkg::ST_STOPPED: begin
                if (resetRise) begin
                    next_runState = sysctl_pkg::ST_BOOT;
                end else if (irqPending && !haltedClock) begin
                    next_runState = sysctl_pkg::ST_RUN;
                end
            end
            default: next_runState = sysctl_pkg::ST_RESET;
        endcase
        if (!system_reset_n_in) begin
            next_runState = sysctl_pkg::ST_RESET;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            runState <= sysctl_pkg::ST_RESET;
        end else begin
            runState <= next_runState;
        end
    end

    // Reset sequence counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bootCount <= 4'h0;
        end else if (next_runState == sysctl_pkg::ST_BOOT && runState != sysctl_pkg::ST_BOOT) begin
            bootCount <= sysctl_pkg::RESET_SEQUENCE_CYCLES;
        end else if (bootCount != 4'h0) begin
            bootCount <= bootCount - 4'h1;
        end
    end

    // Halt instruction stops the phase clock; only the reset pin restarts it, not an interrupt
    always_ff @(posedge core_clk) begin
        if (rst) begin
            haltedClock <= 1'b0;
        end else if (next_runState != sysctl_pkg::ST_STOPPED) begin
            haltedClock <= 1'b0;
        end else if (runState == sysctl_pkg::ST_RUN && regBus.cmdHalt) begin
            haltedClock <= 1'b1;
        end
    end

    // Run level never looks at the surrender pin
    assign runLevel = runState == sysctl_pkg::ST_RUN || runState == sysctl_pkg::ST_BOOT;

    // Run pin: fetch flag in low half only in emulation
    always_ff @(posedge core_clk) begin
        if (rst) begin
            runPin <= 1'b0;
        end else if (emulation && !phase) begin
            runPin <= opcodeFetch;
        end else begin
            runPin <= runLevel;
        end
    end

    // ***********************************************************
    // Core control
    // ***********************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            surrenderLowPhase <= 1'b0;
        end else if (bus_surrender_in) begin
            surrenderLowPhase <= 1'b0;
        end else if (!phase) begin
            surrenderLowPhase <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            coreHalt <= 1'b1;
            coreReset <= 1'b1;
            bootActive <= 1'b0;
        end else begin
            // Held while run low, surrendered, or ready hold in phase high
            coreHalt <= !runLevel || !bus_surrender_in || (phase && !coreReady);
            coreReset <= runState == sysctl_pkg::ST_RESET;
            bootActive <= runState == sysctl_pkg::ST_BOOT;
        end
    end

    // ***********************************************************
    // Bus pins
    // ***********************************************************
    always_ff @(posedge core_clk) begin
        if (rst || !system_reset_n_in) begin
            write_strobe_n_oe <= 1'b0;
            write_strobe_n_out <= 1'b1;
            addrOe <= 1'b0;
            addrOut <= 16'h0;
            dataOe <= 1'b0;
            dataOut <= 8'h0;
        end else begin
            // Drive only while processor owns the bus
            write_strobe_n_oe <= bus_surrender_in || !surrenderLowPhase;
            write_strobe_n_out <= !(coreAccess && coreWrite && coreExternal);
            addrOe <= bus_surrender_in || !surrenderLowPhase;
            addrOut <= coreAddr;
            dataOe <= (bus_surrender_in || !surrenderLowPhase) && coreAccess && coreWrite
                      && (coreExternal || emulation);
            dataOut <= coreWriteData;
        end
    end

    // DMA requests from the external master
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dmaAddr <= 16'h0;
            dmaWrite <= 1'b0;
            dmaValid <= 1'b0;
        end else begin
            dmaAddr <= coreAddr;
            dmaWrite <= !write_strobe_n_in;
            dmaValid <= surrenderLowPhase && !bus_surrender_in;
        end
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    property p_boot_len;
        @(posedge core_clk) disable iff (rst)
        (runState == sysctl_pkg::ST_BOOT && $past(runState) != sysctl_pkg::ST_BOOT && system_reset_n_in)
        ##1 system_reset_n_in [*8] |=> runState == sysctl_pkg::ST_RUN;
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("reset sequence length wrong");

    property p_osc_reset;
        @(posedge core_clk) rst |=> !fastOscEnable;
    endproperty
    a_osc_reset: assert property (p_osc_reset) else $error("fast oscillator not off after reset");

    property p_halt_clock;
        @(posedge core_clk) disable iff (rst)
        haltedClock |=> $stable(phase);
    endproperty
    a_halt_clock: assert property (p_halt_clock) else $error("phase clock moved while halted");

    property p_run_normal;
        @(posedge core_clk) disable iff (rst)
        !emulation |=> runPin == $past(runLevel);
    endproperty
    a_run_normal: assert property (p_run_normal) else $error("run pin wrong in normal mode");

    property p_run_emul;
        @(posedge core_clk) disable iff (rst)
        (emulation && !phase) |=> runPin == $past(opcodeFetch);
    endproperty
    a_run_emul: assert property (p_run_emul) else $error("fetch flag not shown");

    property p_strobe_internal;
        @(posedge core_clk) disable iff (rst)
        !(coreAccess && coreWrite && coreExternal) |=> write_strobe_n_out;
    endproperty
    a_strobe_internal: assert property (p_strobe_internal) else $error("strobe low on non external write");

    property p_bcr_load;
        @(posedge core_clk) disable iff (rst)
        resetRise |=> regBus.busControl == ($past(bus_surrender_in) ? 8'h00 : 8'h89);
    endproperty
    a_bcr_load: assert property (p_bcr_load) else $error("bus control load wrong");

    property p_surrender_halt;
        @(posedge core_clk) disable iff (rst)
        !bus_surrender_in |=> coreHalt;
    endproperty
    a_surrender_halt: assert property (p_surrender_halt) else $error("core runs while surrendered");

    property p_low_power;
        @(posedge core_clk) disable iff (rst)
        lowPower |-> !$past(system_reset_n_in);
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power with reset high");

    c_wait: cover property (@(posedge core_clk) disable iff (rst) regBus.cmdWait ##[1:4] !runLevel);
    c_halt: cover property (@(posedge core_clk) disable iff (rst) haltedClock ##[1:50] resetRise);
    c_dma: cover property (@(posedge core_clk) disable iff (rst) dmaValid && dmaWrite);

endmodule
`default_nettype wire

/* File: sim/dma_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_master_model (
    input wire logic core_clk,
    input wire logic takeBus,
    input wire logic doWrite,
    output logic bus_surrender_in,
    output logic strobeLevel,
    output logic strobeDrive
);
    logic scramble = 1'b0;
    // Released strobe shows a changing pattern, not a held value
    always @(posedge core_clk) scramble <= ~scramble;
    // Surrender the bus and drive the strobe only while holding it
    assign bus_surrender_in = ~takeBus;
    assign strobeDrive = takeBus;
    assign strobeLevel = takeBus ? ~doWrite : scramble;
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slowClockIn = 1'b0, fast_clock_in = 1'b0, opcodeFetch = 1'b0;
    logic coreWrite = 1'b0, coreExternal = 1'b0, coreAccess = 1'b0, irqPending = 1'b0, coreReady = 1'b1;
    logic takeBus = 1'b0, doWrite = 1'b0, pinDrive = 1'b1, slow_osc_drive_out, fastOscEnable;
    logic system_phase_clock, coreHalt, bootActive, lowPower, system_reset_n_in, system_reset_n_out;
    logic system_reset_n_oe, bus_surrender_in, write_strobe_n_in, write_strobe_n_out, ph;
    logic write_strobe_n_oe, strobeLevel, strobeDrive, runPin, dmaWrite, addrOe, dataOe, dmaValid;
    int bad_count = 0, cmp_count = 0, n;
    // ***********************************************************
    // Clocks, pins and instances
    // ***********************************************************
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) fast_clock_in <= ~fast_clock_in;
    // Slow clock kept at a sixteenth of the core rate
    always begin
        repeat (8) @(posedge core_clk);
        slowClockIn <= ~slowClockIn;
    end
    assign write_strobe_n_in = write_strobe_n_oe ? write_strobe_n_out : strobeLevel;
    assign system_reset_n_in = system_reset_n_oe ? system_reset_n_out : pinDrive;
    dma_master_model u_dma (.core_clk, .takeBus, .doWrite, .bus_surrender_in, .strobeLevel, .strobeDrive);
    system_clock_run_bus_reset_control u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .slowClockIn, .fast_clock_in, .slow_osc_drive_out,
        .fast_osc_drive_out(), .fastOscEnable, .system_phase_clock, .phase_clock_inverted(), .opcodeFetch,
        .coreWrite, .coreExternal, .coreAccess, .coreReady, .coreAddr(16'h1234),
        .coreWriteData(8'h5a), .irqPending, .coreHalt, .coreReset(), .bootActive, .lowPower,
        .bus_surrender_in, .system_reset_n_in, .system_reset_n_out, .system_reset_n_oe, .write_strobe_n_in,
        .write_strobe_n_out, .write_strobe_n_oe, .addrOut(), .addrOe, .dataOut(), .dataOe, .runPin,
        .dmaAddr(), .dmaWrite, .dmaValid);
    // ***********************************************************
    // Helpers
    // ***********************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 1, 0);
    endtask
    task automatic phase(input logic v);
        while (system_phase_clock !== ~v) @(posedge core_clk);
        while (system_phase_clock !== v) @(posedge core_clk);
    endtask
    task automatic pin_reset();
        pinDrive <= 1'b0;
        repeat (40) @(posedge core_clk);
        chk("oe in reset", 0, {addrOe, dataOe});
        chk("low power", 1, lowPower);
        pinDrive <= 1'b1;
    endtask
    task automatic complete_run();
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
    // ***********************************************************
    // Test sequence
    // ***********************************************************
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, sysctl_pkg::SPEED_CTRL_OFFSET, 0);
        chk("speed reset", 0, rd);
        phase(1);
        repeat (3) @(posedge core_clk);
        chk("slow drive", !slowClockIn, slow_osc_drive_out);
        for (int i = 0; i < 2; i++) begin
            takeBus <= (i == 0);
            pin_reset();
            @(posedge core_clk);
            takeBus <= 1'b0;
            for (n = 0; n < 40 && bootActive !== 1'b1; n++) @(posedge core_clk);
            for (n = 0; n < 40 && bootActive === 1'b1; n++) @(posedge core_clk);
            chk("boot cycles", 9, n);
            apb(0, sysctl_pkg::BUS_CTRL_OFFSET, 0);
            chk("bus control", i == 0 ? 32'h89 : 32'h0, rd);
        end
        apb(1, sysctl_pkg::SPEED_CTRL_OFFSET, 3);
        apb(0, sysctl_pkg::SPEED_CTRL_OFFSET, 0);
        chk("speed", 3, rd);
        chk("fast enable", 1, fastOscEnable);
        ph = system_phase_clock;
        @(posedge core_clk);
        chk("fast phase", !ph, system_phase_clock);
        // Back to the slow source so that phase halves last several cycles
        apb(1, sysctl_pkg::SPEED_CTRL_OFFSET, 1);
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            opcodeFetch <= i[0];
            chk("run normal", 1, runPin);
        end
        apb(1, sysctl_pkg::BUS_CTRL_OFFSET, 32'h89);
        opcodeFetch <= 1'b0;
        for (n = 0; n < 40 && runPin !== 1'b0; n++) @(posedge core_clk);
        chk("fetch flag", 0, runPin);
        apb(1, sysctl_pkg::BUS_CTRL_OFFSET, 0);
        coreAccess <= 1'b1;
        coreWrite <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("strobe internal", 1, write_strobe_n_out);
        coreExternal <= 1'b1;
        for (n = 0; n < 10 && write_strobe_n_out !== 1'b0; n++) @(posedge core_clk);
        chk("strobe external", 0, write_strobe_n_out);
        chk("data drive", 1, dataOe);
        coreAccess <= 1'b0;
        phase(1);
        takeBus <= 1'b1;
        for (n = 0; n < 10 && coreHalt !== 1'b1; n++) @(posedge core_clk);
        chk("step hold", 1, coreHalt);
        chk("strobe kept", 1, write_strobe_n_oe);
        chk("run kept", 1, runPin);
        takeBus <= 1'b0;
        // Ready hold only counts in the phase high half
        phase(1);
        coreReady <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("ready hold", 1, coreHalt);
        phase(0);
        chk("ready low phase", 0, coreHalt);
        coreReady <= 1'b1;
        phase(0);
        takeBus <= 1'b1;
        doWrite <= 1'b1;
        for (n = 0; n < 10 && dmaWrite !== 1'b1; n++) @(posedge core_clk);
        chk("dma write", 1, dmaWrite);
        chk("dma valid", 1, dmaValid);
        chk("strobe input", 0, write_strobe_n_oe);
        takeBus <= 1'b0;
        doWrite <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk("strobe driven", 1, write_strobe_n_oe);
        for (int c = 1; c < 3; c++) begin
            phase(1);
            apb(1, sysctl_pkg::CORE_CMD_OFFSET, c);
            for (n = 0; n < 40 && runPin !== 1'b0; n++) @(posedge core_clk);
            chk("run low", 0, runPin);
            ph = system_phase_clock;
            irqPending <= 1'b1;
            repeat (40) @(posedge core_clk);
            chk("irq wake", c == 1, runPin);
            if (c == 2) chk("phase frozen", ph, system_phase_clock);
            irqPending <= 1'b0;
        end
        pin_reset();
        for (n = 0; n < 60 && runPin !== 1'b1; n++) @(posedge core_clk);
        chk("reset wake", 1, runPin);
        apb(1, sysctl_pkg::CORE_CMD_OFFSET, 4);
        for (n = 0; n < 10 && system_reset_n_oe !== 1'b1; n++) @(posedge core_clk);
        chk("monitor reset", 1, system_reset_n_oe);
        repeat (60) @(posedge core_clk);
        apb(0, 12'h010, 0);
        chk("unmapped", 1, er);
        complete_run();
    end
endmodule
`default_nettype wire
